// ==== include/irq_ctrl_pkg.sv ====
// constants, register map and types of the two-level interrupt controller
package irq_ctrl_pkg;
  localparam int unsigned NUM_SOURCES = 15;
  localparam int unsigned SRC_W       = 4;

  // register byte addresses
  localparam logic [7:0] ADDR_ENABLE_A = 8'h00;
  localparam logic [7:0] ADDR_ENABLE_B = 8'h04;
  localparam logic [7:0] ADDR_PRIO     = 8'h08;
  localparam logic [7:0] ADDR_PENDING  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_AUTOCLR  = 8'h14;
  localparam logic [7:0] ADDR_SET      = 8'h18;
  localparam logic [7:0] ADDR_CLEAR    = 8'h1c;

  // field positions
  localparam int unsigned GIE_BIT     = 7;
  localparam int unsigned SRC_A_COUNT = 7;
  localparam int unsigned SRC_B_COUNT = 8;
  localparam int unsigned ST_REQ_BIT  = 0;
  localparam int unsigned ST_HI_BIT   = 1;
  localparam int unsigned ST_LO_BIT   = 2;
  localparam int unsigned ST_SRC_LSB  = 4;

  // reset values
  localparam logic [7:0]  ENABLE_RST  = 8'h00;
  localparam logic [14:0] PRIO_RST    = 15'h0000;
  localparam logic [14:0] PENDING_RST = 15'h0000;
  // sources 0..3 are cleared by hardware on vectoring
  localparam logic [14:0] AUTOCLR_DEF = 15'h000f;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // vector address: base plus 8 bytes per source
  localparam logic [15:0] VECTOR_BASE = 16'h0003;
  localparam int unsigned VECTOR_SHIFT = 3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ACK   = 2'b01,
    ST_SERVE = 2'b11
  } core_state_t;
endpackage

// ==== src/irq_ctrl.sv ====
// two-level interrupt controller with AXI4-Lite register access
// Operation
// R1: many sources, each assigned to one of two priority levels
// R2: a source's valid condition sets its pending flag to one
// R3: pending flag is set whether the source is enabled or not
// R4: request goes to the CPU whenever an enabled pending flag is set
// R5: CPU finishes current instruction, then long calls the source's fixed vector
// R6: every routine ends with return from interrupt, resuming the interrupted flow
// R7: a disabled source's pending flag is ignored, no vectoring
// R8: each source has its own enable bit in one of two enable registers
// R9: individual enables count only while the global enable is one
// R10: global enable zero blocks every source regardless of individual enables
// R11: certain sources have their flag cleared by hardware on vectoring
// R12: other sources' routines must clear the flag before returning
// R13: flag still set after return requests again, re-entry after one instruction; the code re-enters only after two instructions
// R14: high priority preempts low priority routine; high routine never preempted
// R15: simultaneous requests: higher priority first, ties by fixed source order
// R16: software writing one to a pending flag requests like hardware
// R17: pending flags hold until cleared by vectoring or software
`timescale 1ns/1ns
module irq_ctrl
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rstn,
  // interrupt sources, one-cycle condition pulses
  input  wire logic [NUM_SOURCES-1:0] src_event,
  // cpu core sequencer
  input  wire logic                   instr_done,
  input  wire logic                   return_from_interrupt,
  output logic                        irq_request,
  output logic                        long_call_to_vector,
  output logic [15:0]                 vector_addr,
  output logic [SRC_W-1:0]            vector_src,
  // axi4-lite write address
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [7:0]             s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  // axi4-lite write response
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic [1:0]                  s_axi_bresp,
  // axi4-lite read address
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [7:0]             s_axi_araddr,
  // axi4-lite read data
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp
);

  logic                   rst_meta_reg;
  logic                   rst_sync_reg;
  logic [7:0]             enable_a_reg;
  logic [7:0]             enable_b_reg;
  logic [NUM_SOURCES-1:0] prio_reg;
  logic [NUM_SOURCES-1:0] pending_reg;
  logic [NUM_SOURCES-1:0] pending_next;
  logic [NUM_SOURCES-1:0] autoclr_reg;
  logic [NUM_SOURCES-1:0] src_enable;
  logic [NUM_SOURCES-1:0] active;
  logic                   global_irq_enable;
  logic                   hi_active_reg;
  logic                   lo_active_reg;
  logic [SRC_W-1:0]       hi_src_reg;
  logic [SRC_W-1:0]       lo_src_reg;
  core_state_t            state_reg;
  logic [SRC_W-1:0]       win_src;
  logic                   win_hi;
  logic                   win_valid;
  logic                   may_take;
  logic                   take;
  logic                   return_from_interrupt_guard_reg;
  logic [7:0]             aw_addr_reg;
  logic                   aw_held_reg;
  logic [31:0]            w_data_reg;
  logic [3:0]             w_strb_reg;
  logic                   w_held_reg;
  logic                   wr_fire;
  logic [31:0]            rd_value;
  logic                   rd_hit;
  logic [NUM_SOURCES-1:0] sw_set;
  logic [NUM_SOURCES-1:0] sw_clr;
  logic [NUM_SOURCES-1:0] hw_clr;

  // reset release through two flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign global_irq_enable = enable_a_reg[GIE_BIT];
  assign src_enable = {enable_b_reg, enable_a_reg[SRC_A_COUNT-1:0]};  // [R8]
  // global enable gates every individual enable
  assign active = global_irq_enable ? (pending_reg & src_enable) : '0;  // [R4] [R7] [R9] [R10]

  // winner: high level first, lowest index wins a tie
  always_comb begin
    win_src   = '0;
    win_hi    = 1'b0;
    win_valid = 1'b0;
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (active[i] && !prio_reg[i]) begin  // [R15]
        win_src   = SRC_W'(i);
        win_valid = 1'b1;
      end
    end
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (active[i] && prio_reg[i]) begin  // [R1] [R15]
        win_src   = SRC_W'(i);
        win_hi    = 1'b1;
        win_valid = 1'b1;
      end
    end
  end

  // a running high routine is never preempted; low routine yields only to high
  always_comb begin
    if (hi_active_reg)
      may_take = 1'b0;  // [R14]
    else if (lo_active_reg)
      may_take = win_hi;  // [R14]
    else
      may_take = 1'b1;
  end

  // after a return two more instructions run before re-entry
  assign take = win_valid && may_take && instr_done && !return_from_interrupt_guard_reg
                && (state_reg == ST_IDLE);  // [R5] [R13]

  // vectoring sequence
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
    end else if (!rst_sync_reg) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE:  if (take) state_reg <= ST_ACK;
        ST_ACK:   state_reg <= ST_SERVE;
        ST_SERVE: state_reg <= ST_IDLE;
      endcase
    end
  end

  // nesting record of active routines
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hi_active_reg <= 1'b0;
      lo_active_reg <= 1'b0;
      hi_src_reg    <= '0;
      lo_src_reg    <= '0;
    end else if (!rst_sync_reg) begin
      hi_active_reg <= 1'b0;
      lo_active_reg <= 1'b0;
    end else if (take) begin
      if (win_hi) begin
        hi_active_reg <= 1'b1;
        hi_src_reg    <= win_src;
      end else begin
        lo_active_reg <= 1'b1;
        lo_src_reg    <= win_src;
      end
    end else if (return_from_interrupt) begin
      // the innermost routine returns first
      if (hi_active_reg)
        hi_active_reg <= 1'b0;  // [R6]
      else
        lo_active_reg <= 1'b0;  // [R6]
    end
  end

  // blocks vectoring until the instruction after a return completes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      return_from_interrupt_guard_reg <= 1'b0;
    else if (return_from_interrupt)
      return_from_interrupt_guard_reg <= 1'b1;  // [R13]
    else if (instr_done)
      return_from_interrupt_guard_reg <= 1'b0;
  end

  // cpu outputs
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_request         <= 1'b0;
      long_call_to_vector <= 1'b0;
      vector_addr         <= '0;
      vector_src          <= '0;
    end else begin
      irq_request         <= win_valid && may_take;  // [R4] [R13]
      long_call_to_vector <= take;  // [R5]
      if (take) begin
        vector_src  <= win_src;
        vector_addr <= VECTOR_BASE + (16'(win_src) << VECTOR_SHIFT);  // [R5]
      end
    end
  end

  // pending flags
  assign hw_clr = take ? (autoclr_reg & (NUM_SOURCES'(1) << win_src)) : '0;  // [R11]
  always_comb begin
    // events win over any clear in the same cycle
    pending_next = (pending_reg & ~sw_clr & ~hw_clr) | sw_set | src_event;  // [R2] [R3] [R16] [R17]
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn)
      pending_reg <= PENDING_RST;
    else
      pending_reg <= pending_next;  // [R17]
  end

  // axi write channels: address and data accepted in either order
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= rst_sync_reg && !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= rst_sync_reg && !w_held_reg && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // strobe-qualified software set and clear of flags
  always_comb begin
    sw_set = '0;
    sw_clr = '0;
    if (wr_fire && w_strb_reg[0] && w_strb_reg[1]) begin
      if (aw_addr_reg == ADDR_SET)
        sw_set = w_data_reg[NUM_SOURCES-1:0];  // [R16]
      if (aw_addr_reg == ADDR_CLEAR)
        sw_clr = w_data_reg[NUM_SOURCES-1:0];  // [R12]
      if (aw_addr_reg == ADDR_PENDING) begin
        sw_set = w_data_reg[NUM_SOURCES-1:0];  // [R16]
        sw_clr = ~w_data_reg[NUM_SOURCES-1:0];
      end
    end
  end

  // control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enable_a_reg <= ENABLE_RST;
      enable_b_reg <= ENABLE_RST;
      prio_reg     <= PRIO_RST;
      autoclr_reg  <= AUTOCLR_DEF;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        ADDR_ENABLE_A: if (w_strb_reg[0]) enable_a_reg <= w_data_reg[7:0];  // [R8] [R9]
        ADDR_ENABLE_B: if (w_strb_reg[0]) enable_b_reg <= w_data_reg[7:0];  // [R8]
        ADDR_PRIO: begin
          if (w_strb_reg[0]) prio_reg[7:0] <= w_data_reg[7:0];  // [R1]
          if (w_strb_reg[1]) prio_reg[NUM_SOURCES-1:8] <= w_data_reg[NUM_SOURCES-1:8];
        end
        ADDR_AUTOCLR: begin
          if (w_strb_reg[0]) autoclr_reg[7:0] <= w_data_reg[7:0];
          if (w_strb_reg[1]) autoclr_reg[NUM_SOURCES-1:8] <= w_data_reg[NUM_SOURCES-1:8];
        end
        default: ;
      endcase
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr_reg)
        ADDR_ENABLE_A, ADDR_ENABLE_B, ADDR_PRIO, ADDR_PENDING,
        ADDR_AUTOCLR, ADDR_SET, ADDR_CLEAR: s_axi_bresp <= RESP_OKAY;
        default:                            s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_value = '0;
    rd_hit   = 1'b1;
    unique case (s_axi_araddr)
      ADDR_ENABLE_A: rd_value[7:0] = enable_a_reg;
      ADDR_ENABLE_B: rd_value[7:0] = enable_b_reg;
      ADDR_PRIO:     rd_value[NUM_SOURCES-1:0] = prio_reg;
      ADDR_PENDING:  rd_value[NUM_SOURCES-1:0] = pending_reg;
      ADDR_AUTOCLR:  rd_value[NUM_SOURCES-1:0] = autoclr_reg;
      ADDR_STATUS: begin
        rd_value[ST_REQ_BIT] = irq_request;
        rd_value[ST_HI_BIT]  = hi_active_reg;
        rd_value[ST_LO_BIT]  = lo_active_reg;
        rd_value[ST_SRC_LSB +: SRC_W] = hi_active_reg ? hi_src_reg : lo_src_reg;
      end
      ADDR_SET, ADDR_CLEAR: rd_value = '0;
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= rst_sync_reg && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_value;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ==== test/irq_ctrl_properties.sv ====
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module irq_ctrl_properties
  import irq_ctrl_pkg::*;
(
  // clock and reset
  input wire logic             clock,
  input wire logic             rstn,
  // cpu side
  input wire logic             instr_done,
  input wire logic             return_from_interrupt,
  input wire logic             long_call_to_vector,
  input wire logic [15:0]      vector_addr,
  input wire logic [SRC_W-1:0] vector_src,
  // bus side
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  input wire logic [1:0]       s_axi_bresp
);
  // set by a return, cleared by the first instruction after it, which may not vector
  logic skip_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) skip_reg <= 1'b0;
    else if (return_from_interrupt) skip_reg <= 1'b1;
    else if (instr_done) skip_reg <= 1'b0;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence call_gap;
    !long_call_to_vector [*2];
  endsequence

  chk_vec_addr:
    assert property (long_call_to_vector |-> vector_addr == VECTOR_BASE + (16'(vector_src) << VECTOR_SHIFT))
    else $error("vector address does not match source");
  chk_call_gap:
    assert property (long_call_to_vector |=> call_gap) else $error("vector calls too close");
  chk_call_cause:
    assert property (long_call_to_vector |-> $past(instr_done)) else $error("vector call without instruction end");
  chk_src_range:
    assert property (long_call_to_vector |-> vector_src < NUM_SOURCES) else $error("vector source out of range");
  chk_vec_hold:
    assert property (!long_call_to_vector |-> $stable(vector_src)) else $error("vector source changed between calls");
  chk_ret_skip:
    assert property (instr_done && skip_reg |=> !long_call_to_vector) else $error("vectored on first instruction after return");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
endmodule

bind irq_ctrl irq_ctrl_properties chk (.clock, .rstn, .instr_done, .return_from_interrupt, .long_call_to_vector,
  .vector_addr, .vector_src, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp);

// ==== test/cpu_model.sv ====
// cpu sequencer model: fixed-length instructions, return on command
`timescale 1ns/1ns
module cpu_model #(
  parameter int unsigned INSTR_CYC = 4
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // bench command: end the running routine
  input  wire logic ret_cmd,
  // to the controller
  output logic      instr_done,
  output logic      return_from_interrupt
);
  logic [3:0] cnt_reg;
  logic       ret_reg;
  logic       last;
  assign last = cnt_reg == 4'(INSTR_CYC - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) cnt_reg <= 4'h0;
    else cnt_reg <= last ? 4'h0 : cnt_reg + 4'h1;
  end
  // a return takes the next instruction slot, so it never coincides with instr_done
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ret_reg <= 1'b0;
    else if (ret_cmd) ret_reg <= 1'b1;
    else if (last) ret_reg <= 1'b0;
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      instr_done            <= 1'b0;
      return_from_interrupt <= 1'b0;
    end else begin
      instr_done            <= last && !ret_reg;
      return_from_interrupt <= last && ret_reg;
    end
  end
endmodule

// ==== test/tb_irq_ctrl.sv ====
// self-checking bench of the interrupt controller
`timescale 1ns/1ns
module tb_irq_ctrl
  import irq_ctrl_pkg::*;
;
  typedef struct {
    int   s;
    logic [7:0] ea;
    logic [7:0] eb;
    logic call;
    logic pend;
  } row_t;
  // one source each: enables, expected vectoring, pending afterwards
  row_t rows [5] = '{'{0, 8'h81, 8'h00, 1, 0}, '{9, 8'h80, 8'h00, 0, 1}, '{5, 8'h20, 8'h00, 0, 1},
                     '{14, 8'h80, 8'h80, 1, 1}, '{6, 8'hc0, 8'h00, 1, 1}};

  logic                   clock = 0;
  logic                   rstn;
  logic [NUM_SOURCES-1:0] src_event;
  logic                   instr_done, return_from_interrupt, ret_cmd;
  logic                   irq_request, long_call_to_vector;
  logic [15:0]            vector_addr;
  logic [SRC_W-1:0]       vector_src, last_src;
  logic                   awvalid, awready, wvalid, wready, bvalid, bready;
  logic                   arvalid, arready, rvalid, rready;
  logic [7:0]             awaddr, araddr;
  logic [31:0]            wdata, rdata;
  logic [3:0]             wstrb;
  logic [1:0]             bresp, rresp;
  int                     num_errors = 0, samples_checked = 0, calls = 0, ic = 0, call_ic, ret_ic;

  always #2 clock = ~clock;

  irq_ctrl dut (.clock, .rstn, .src_event, .instr_done, .return_from_interrupt, .irq_request,
    .long_call_to_vector, .vector_addr, .vector_src, .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  cpu_model cpu (.clock, .rstn, .ret_cmd, .instr_done, .return_from_interrupt);

  always @(posedge clock) begin
    if (instr_done) ic <= ic + 1;
    if (return_from_interrupt) ret_ic <= ic;
    if (long_call_to_vector) begin
      calls    <= calls + 1;
      last_src <= vector_src;
      call_ic  <= ic;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string n);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad, dd;
    ad = 0;
    dd = 0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    while (!(ad && dd)) begin
      @(posedge clock);
      ad = ad | awready;
      dd = dd | wready;
      awvalid <= !ad;
      wvalid  <= !dd;
    end
    while (!bvalid) @(posedge clock);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clock);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  task automatic fire(input logic [14:0] m);
    src_event <= m;
    @(posedge clock);
    src_event <= '0;
  endtask
  // a quiet source is judged after this bounded wait
  task automatic wait_call(input int c0);
    repeat (60) if (calls == c0) @(posedge clock);
  endtask
  task automatic ret_isr();
    ret_cmd <= 1;
    @(posedge clock);
    ret_cmd <= 0;
    repeat (40) if (!return_from_interrupt) @(posedge clock);
    @(posedge clock);
  endtask
  // wait for the call, check its source, then clear the flag; the return is left to ret_isr
  task automatic serve(input int s, input int c0);
    wait_call(c0);
    check(32'(last_src), 32'(s), "vector_src");
    wr(ADDR_CLEAR, 32'h1 << s);
  endtask

  initial begin
    int c0;
    logic [31:0] d;
    logic [1:0] r;
    {rstn, src_event, ret_cmd, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (20) @(posedge clock);
    rstn <= 1;
    rd(ADDR_ENABLE_A, d, r);
    check(d, 32'(ENABLE_RST), "enable_a");
    rd(ADDR_AUTOCLR, d, r);
    check(d, 32'(AUTOCLR_DEF), "autoclr");
    rd(8'h40, d, r);
    check(32'(r), 32'(RESP_SLVERR), "unmapped");
    wr(8'h40, 32'h0);
    check(32'(bresp), 32'(RESP_SLVERR), "unmapped_wr");
    $display("test reset done");
    foreach (rows[i]) begin
      wr(ADDR_ENABLE_A, 32'(rows[i].ea));
      wr(ADDR_ENABLE_B, 32'(rows[i].eb));
      c0 = calls;
      fire(15'h1 << rows[i].s);
      wait_call(c0);
      check(32'(calls - c0), 32'(rows[i].call), "calls");
      if (rows[i].call) check(32'(last_src), 32'(rows[i].s), "vector_src");
      rd(ADDR_PENDING, d, r);
      check(32'(d[rows[i].s]), 32'(rows[i].pend), "pending");
      wr(ADDR_CLEAR, 32'h1 << rows[i].s);
      if (rows[i].call) ret_isr();
      $display("test row %0d done", i);
    end
    wr(ADDR_ENABLE_A, 32'hff);
    wr(ADDR_ENABLE_B, 32'hff);
    wr(ADDR_PRIO, 32'h1c00);
    check(32'(bresp), 32'(RESP_OKAY), "mapped_wr");
    c0 = calls;
    fire(15'h0408);
    serve(10, c0);
    c0 = calls;
    ret_isr();
    wait_call(c0);
    c0 = calls;
    fire(15'h0800);
    serve(11, c0);
    c0 = calls;
    fire(15'h1000);
    wait_call(c0);
    check(32'(calls - c0), 32'h0, "preempt_high");
    check(32'(irq_request), 32'h0, "irq_blocked");
    // both levels active, high routine 11 innermost, nothing may vector
    rd(ADDR_STATUS, d, r);
    check(d, (32'd11 << ST_SRC_LSB) | (32'h1 << ST_HI_BIT) | (32'h1 << ST_LO_BIT), "status");
    rd(ADDR_PENDING, d, r);
    check(32'(d[12]), 32'h1, "pending_held");
    ret_isr();
    serve(12, c0);
    ret_isr();
    ret_isr();
    $display("test priority done");
    c0 = calls;
    fire(15'h0030);
    serve(4, c0);
    ret_isr();
    serve(5, c0 + 1);
    ret_isr();
    c0 = calls;
    fire(15'h0100);
    wait_call(c0);
    ret_isr();
    wait_call(c0 + 1);
    check(32'(calls - c0), 32'h2, "reentry");
    check(32'(call_ic - ret_ic), 32'h2, "reentry_instr");
    wr(ADDR_CLEAR, 32'h0100);
    ret_isr();
    c0 = calls;
    wr(ADDR_SET, 32'h2000);
    serve(13, c0);
    ret_isr();
    $display("test corner cases done");
    complete_run();
  end

  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule
